// ===== logic/code_match_unit.v
// Purpose: one repeating loop-code detector working on the received bit stream.
// Assumes: bit_valid marks each received bit, synchronous to core_clk.
// Notes:   a code is locked when the last N bits equal the pattern exactly,
//          then must keep repeating with period N for the integration period.
`timescale 1ns/100ps
`default_nettype none
`include "loop_code_regs.vh"

module code_match_unit
(
  // clock, reset, enable
  input wire core_clk,
  input wire rst,
  input wire clk_en,
  // received stream
  input wire bit_valid,
  input wire bit_in,
  // programmed code
  input wire [7:0] pat_hi,
  input wire [7:0] pat_lo,
  input wire [2:0] len_sel,
  input wire restart,
  input wire [11:0] threshold,
  // result
  output reg detected_ff
);

  reg [15:0] hist_ff;
  reg [4:0] fill_ff;
  reg lock_ff;
  reg [11:0] run_ff;

  wire [15:0] win;
  wire long_code;
  wire [3:0] lag_idx;
  wire [2:0] drop;
  wire [7:0] short_exp;
  wire [7:0] short_mask;
  wire exact;
  wire period_ok;
  wire filled;

  // ************************************************************
  // pattern compare
  // ************************************************************
  // newest bit sits in win[0]; the oldest bit of the window meets the msb
  assign win = {hist_ff[14:0], bit_in};
  assign long_code = (len_sel == `LENGTH_SEL_LONG); // [RL5] [RL6] [RL7]
  // one bit less than the code length, i.e. bit_in is compared N bits back
  assign lag_idx = long_code ? 4'hf : {1'b0, len_sel};
  assign drop = 3'h7 - len_sel;
  assign short_exp = pat_hi >> drop; // [RL2] [RL3]
  assign short_mask = 8'hff >> drop; // [RL3]
  // lo pattern only joins in for the 8/16 bit setting
  assign exact = long_code ? (win == {pat_hi, pat_lo}) :
                 (((win[7:0] ^ short_exp) & short_mask) == 8'h00); // [RL4]
  assign period_ok = (bit_in == hist_ff[lag_idx]);
  assign filled = (fill_ff >= {1'b0, lag_idx});

  // ************************************************************
  // integration
  // ************************************************************
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      hist_ff <= 16'h0000;
      fill_ff <= 5'h00;
      lock_ff <= 1'b0;
      run_ff <= 12'h000;
      detected_ff <= 1'b0;
    end
    else if (clk_en)
    begin
      if (restart)
      begin
        // stale history would fake a match against the new pattern
        hist_ff <= 16'h0000; // [RL1]
        fill_ff <= 5'h00; // [RL1]
        lock_ff <= 1'b0; // [RL1]
        run_ff <= 12'h000; // [RL1]
        detected_ff <= 1'b0; // [RL1]
      end
      else if (bit_valid)
      begin
        hist_ff <= win;
        if (fill_ff != `HIST_FULL)
        begin
          fill_ff <= fill_ff + 5'h01;
        end
        if (lock_ff && period_ok)
        begin
          if (run_ff != 12'hfff)
          begin
            run_ff <= run_ff + 12'h001;
          end
          detected_ff <= (run_ff >= threshold); // [RL10]
        end
        else
        begin
          // any break in the repetition starts the period over
          lock_ff <= filled & exact; // [RL10]
          run_ff <= 12'h000;
          detected_ff <= 1'b0; // [RL10]
        end
      end
    end
  end

endmodule
`default_nettype wire

// ===== logic/loop_code_detector.v
// Purpose: receive in-band loop-code detection with up, down and spare
//          detectors, programmed over an Avalon-MM slave port.
// Assumes: rx_bit_valid and rx_bit are synchronous to core_clk.
// Notes:   every bus access answers with one wait cycle.
//
// Overview of operation
// RL1 - writing a detector's first pattern register restarts its integration from zero.
// RL2 - msb of the first pattern register is the first bit of the code.
// RL3 - for lengths one to seven only the top N bits are compared.
// RL4 - second pattern register is ignored for lengths one to seven.
// RL5 - up-code length is a 3-bit field; 111 selects 8/16 bits.
// RL6 - down-code length is its own 3-bit field, same encoding.
// RL7 - spare length comes from low three bits of its control register.
// RL8 - software keeps the five upper spare control bits at zero.
// RL9 - a third spare detector has its own pattern register pair.
// RL10 - code is declared present after error-free repetition for a whole integration period.
`timescale 1ns/100ps
`default_nettype none
`include "loop_code_regs.vh"

module loop_code_detector
(
  // clock, reset, enable
  input wire core_clk,
  input wire rst,
  input wire clk_en,
  // avalon-mm slave
  input wire [9:0] address,
  input wire read,
  input wire write,
  input wire [31:0] writedata,
  input wire [3:0] byteenable,
  output reg [31:0] readdata,
  output reg waitrequest,
  // received t1 stream
  input wire rx_bit_valid,
  input wire rx_bit,
  // detection results
  output wire up_code_detected,
  output wire down_code_detected,
  output wire spare_code_detected
);

  // ************************************************************
  // bus handshake states
  // ************************************************************
  localparam [1:0] ST_IDLE = 2'b01;
  localparam [1:0] ST_ACK = 2'b10;

  reg [1:0] state_ff;
  reg [1:0] nxt_state;

  // ************************************************************
  // register storage
  // ************************************************************
  reg [7:0] up_code_pattern_hi_ff;
  reg [7:0] up_code_pattern_lo_ff;
  reg [7:0] down_code_pattern_hi_ff;
  reg [7:0] down_code_pattern_lo_ff;
  reg [2:0] spare_length_sel_ff;
  reg [7:0] spare_code_pattern_hi_ff;
  reg [7:0] spare_code_pattern_lo_ff;
  reg [5:0] loop_length_ctl_ff;
  reg [7:0] integration_period_ff;

  reg [7:0] rd_mux;

  wire req;
  wire wr_commit;
  wire wr_low_lane;
  wire up_det;
  wire down_det;
  wire spare_det;
  wire [11:0] threshold;
  wire [2:0] up_length_sel;
  wire [2:0] down_length_sel;

  // ************************************************************
  // decode helpers
  // ************************************************************
  // misaligned byte addresses never hit a register
  function reg_hit;
    input [9:0] addr;
    input [7:0] idx;
    begin
      reg_hit = (addr[1:0] == 2'b00) && (addr[9:2] == idx);
    end
  endfunction

  assign req = read | write;
  // narrow registers live in byte lane 0 only
  assign wr_low_lane = byteenable[0];
  // the write lands at the edge where waitrequest is sampled low
  assign wr_commit = clk_en & write & (state_ff == ST_ACK) & wr_low_lane;

  // ************************************************************
  // handshake state machine
  // ************************************************************
  always @*
  begin
    nxt_state = state_ff;
    case (state_ff)
      ST_IDLE:
      begin
        if (req)
        begin
          nxt_state = ST_ACK;
        end
      end
      ST_ACK:
      begin
        nxt_state = ST_IDLE;
      end
      default:
      begin
        nxt_state = ST_IDLE;
      end
    endcase
  end

  always @(posedge core_clk)
  begin
    if (rst)
    begin
      state_ff <= ST_IDLE;
      waitrequest <= 1'b1;
      readdata <= 32'h00000000;
    end
    else if (clk_en)
    begin
      state_ff <= nxt_state;
      // low for exactly the one cycle in which the answer stands
      waitrequest <= ~((state_ff == ST_IDLE) & req);
      if ((state_ff == ST_IDLE) && read)
      begin
        readdata <= {24'h000000, rd_mux};
      end
    end
  end

  // ************************************************************
  // read mux
  // ************************************************************
  always @*
  begin
    rd_mux = 8'h00;
    if (reg_hit(address, `UP_CODE_PATTERN_HI_IDX))
    begin
      rd_mux = up_code_pattern_hi_ff;
    end
    else if (reg_hit(address, `UP_CODE_PATTERN_LO_IDX))
    begin
      rd_mux = up_code_pattern_lo_ff;
    end
    else if (reg_hit(address, `DOWN_CODE_PATTERN_HI_IDX))
    begin
      rd_mux = down_code_pattern_hi_ff;
    end
    else if (reg_hit(address, `DOWN_CODE_PATTERN_LO_IDX))
    begin
      rd_mux = down_code_pattern_lo_ff;
    end
    else if (reg_hit(address, `SPARE_CODE_LENGTH_CTL_IDX))
    begin
      // upper bits are not stored and read back as zero
      rd_mux = {5'h00, spare_length_sel_ff};
    end
    else if (reg_hit(address, `SPARE_CODE_PATTERN_HI_IDX))
    begin
      rd_mux = spare_code_pattern_hi_ff;
    end
    else if (reg_hit(address, `SPARE_CODE_PATTERN_LO_IDX))
    begin
      rd_mux = spare_code_pattern_lo_ff;
    end
    else if (reg_hit(address, `LOOP_LENGTH_CTL_IDX))
    begin
      rd_mux = {2'b00, loop_length_ctl_ff};
    end
    else if (reg_hit(address, `INTEGRATION_PERIOD_IDX))
    begin
      rd_mux = integration_period_ff;
    end
    else if (reg_hit(address, `LOOP_CODE_STATUS_IDX))
    begin
      rd_mux = {5'h00, spare_det, down_det, up_det};
    end
  end

  // ************************************************************
  // pattern registers
  // ************************************************************
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      up_code_pattern_hi_ff <= `PATTERN_RST;
      up_code_pattern_lo_ff <= `PATTERN_RST;
      down_code_pattern_hi_ff <= `PATTERN_RST;
      down_code_pattern_lo_ff <= `PATTERN_RST;
      spare_code_pattern_hi_ff <= `PATTERN_RST;
      spare_code_pattern_lo_ff <= `PATTERN_RST;
    end
    else if (wr_commit)
    begin
      if (reg_hit(address, `UP_CODE_PATTERN_HI_IDX))
      begin
        up_code_pattern_hi_ff <= writedata[7:0];
      end
      if (reg_hit(address, `UP_CODE_PATTERN_LO_IDX))
      begin
        up_code_pattern_lo_ff <= writedata[7:0];
      end
      if (reg_hit(address, `DOWN_CODE_PATTERN_HI_IDX))
      begin
        down_code_pattern_hi_ff <= writedata[7:0];
      end
      if (reg_hit(address, `DOWN_CODE_PATTERN_LO_IDX))
      begin
        down_code_pattern_lo_ff <= writedata[7:0];
      end
      if (reg_hit(address, `SPARE_CODE_PATTERN_HI_IDX))
      begin
        spare_code_pattern_hi_ff <= writedata[7:0]; // [RL9]
      end
      if (reg_hit(address, `SPARE_CODE_PATTERN_LO_IDX))
      begin
        spare_code_pattern_lo_ff <= writedata[7:0]; // [RL9]
      end
    end
  end

  // ************************************************************
  // length and period registers
  // ************************************************************
  always @(posedge core_clk)
  begin
    if (rst)
    begin
      spare_length_sel_ff <= `SPARE_LENGTH_RST;
      loop_length_ctl_ff <= `LENGTH_CTL_RST;
      integration_period_ff <= `INTEGRATION_PERIOD_RST;
    end
    else if (wr_commit)
    begin
      if (reg_hit(address, `SPARE_CODE_LENGTH_CTL_IDX))
      begin
        // bits 7..3 are expected zero and simply dropped
        spare_length_sel_ff <=
          writedata[`SPARE_LENGTH_SEL_MSB:`SPARE_LENGTH_SEL_LSB]; // [RL7] [RL8]
      end
      if (reg_hit(address, `LOOP_LENGTH_CTL_IDX))
      begin
        loop_length_ctl_ff <= writedata[5:0];
      end
      if (reg_hit(address, `INTEGRATION_PERIOD_IDX))
      begin
        integration_period_ff <= writedata[7:0];
      end
    end
  end

  assign up_length_sel =
    loop_length_ctl_ff[`UP_LENGTH_SEL_MSB:`UP_LENGTH_SEL_LSB]; // [RL5]
  assign down_length_sel =
    loop_length_ctl_ff[`DOWN_LENGTH_SEL_MSB:`DOWN_LENGTH_SEL_LSB]; // [RL6]
  // period counts received bits in steps of sixteen
  assign threshold = {integration_period_ff, 4'h0};

  // ************************************************************
  // detectors
  // ************************************************************
  code_match_unit up_unit
  (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .bit_valid(rx_bit_valid),
    .bit_in(rx_bit),
    .pat_hi(up_code_pattern_hi_ff),
    .pat_lo(up_code_pattern_lo_ff),
    .len_sel(up_length_sel),
    .restart(wr_commit & reg_hit(address, `UP_CODE_PATTERN_HI_IDX)), // [RL1]
    .threshold(threshold),
    .detected_ff(up_det)
  );

  code_match_unit down_unit
  (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .bit_valid(rx_bit_valid),
    .bit_in(rx_bit),
    .pat_hi(down_code_pattern_hi_ff),
    .pat_lo(down_code_pattern_lo_ff),
    .len_sel(down_length_sel),
    .restart(wr_commit & reg_hit(address, `DOWN_CODE_PATTERN_HI_IDX)), // [RL1]
    .threshold(threshold),
    .detected_ff(down_det)
  );

  // own pattern pair and length, shares the stream and the integration period with the others
  code_match_unit spare_unit
  (
    .core_clk(core_clk),
    .rst(rst),
    .clk_en(clk_en),
    .bit_valid(rx_bit_valid),
    .bit_in(rx_bit),
    .pat_hi(spare_code_pattern_hi_ff),
    .pat_lo(spare_code_pattern_lo_ff),
    .len_sel(spare_length_sel_ff),
    .restart(wr_commit & reg_hit(address, `SPARE_CODE_PATTERN_HI_IDX)), // [RL1] [RL9]
    .threshold(threshold),
    .detected_ff(spare_det)
  );

  // ************************************************************
  // outputs
  // ************************************************************
  assign up_code_detected = up_det;
  assign down_code_detected = down_det;
  assign spare_code_detected = spare_det;

endmodule
`default_nettype wire

// ===== logic/loop_code_regs.vh
// Purpose: register indices, field positions and reset values of the
//          receive in-band loop-code detector block.
// Assumes: register byte address is four times the register index.
// Notes:   definitions only; no logic lives here.
`ifndef LOOP_CODE_REGS_VH
`define LOOP_CODE_REGS_VH

// ************************************************************
// register indices (byte address = index * 4)
// ************************************************************
`define UP_CODE_PATTERN_HI_IDX 8'hb9
`define UP_CODE_PATTERN_LO_IDX 8'hba
`define DOWN_CODE_PATTERN_HI_IDX 8'hbb
`define DOWN_CODE_PATTERN_LO_IDX 8'hbc
`define SPARE_CODE_LENGTH_CTL_IDX 8'hbd
`define SPARE_CODE_PATTERN_HI_IDX 8'hbe
`define SPARE_CODE_PATTERN_LO_IDX 8'hbf
`define LOOP_LENGTH_CTL_IDX 8'hf0
`define INTEGRATION_PERIOD_IDX 8'hf1
`define LOOP_CODE_STATUS_IDX 8'hf2

// ************************************************************
// field positions
// ************************************************************
`define UP_LENGTH_SEL_MSB 5
`define UP_LENGTH_SEL_LSB 3
`define DOWN_LENGTH_SEL_MSB 2
`define DOWN_LENGTH_SEL_LSB 0
`define SPARE_LENGTH_SEL_MSB 2
`define SPARE_LENGTH_SEL_LSB 0
`define STATUS_UP_BIT 0
`define STATUS_DOWN_BIT 1
`define STATUS_SPARE_BIT 2

// ************************************************************
// reset values and codes
// ************************************************************
`define PATTERN_RST 8'h00
`define LENGTH_CTL_RST 6'h00
`define SPARE_LENGTH_RST 3'h0
`define INTEGRATION_PERIOD_RST 8'h10
`define LENGTH_SEL_LONG 3'h7
`define HIST_FULL 5'h10

`endif

// ===== tb/loop_code_props_properties.sv
// Purpose: bus and detector properties of loop_code_detector.
// Assumes: bound to every loop_code_detector instance.
// Notes: a restart may clear a flag one cycle after the write commits.
`timescale 1ns/100ps
`default_nettype none
`include "loop_code_regs.vh"

module loop_code_props
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  input wire logic clk_en,
  // bus
  input wire logic [9:0] address,
  input wire logic read,
  input wire logic write,
  input wire logic [3:0] byteenable,
  input wire logic [31:0] readdata,
  input wire logic waitrequest,
  // stream and results
  input wire logic rx_bit_valid,
  input wire logic up_code_detected,
  input wire logic down_code_detected,
  input wire logic spare_code_detected
);
  default clocking cb @(posedge core_clk); endclocking
  default disable iff (rst);
  // ****************************************
  // properties
  // ****************************************
  property restart_p(logic [7:0] idx, logic det);
    clk_en && write && !waitrequest && byteenable[0] && address == {idx, 2'b00}
      |=> ##[0:1] !det;
  endproperty
  ack_latency_a: assert property ((read || write) && waitrequest && clk_en |=> !waitrequest)
    else $error("request not answered next cycle");
  ack_single_a: assert property (!waitrequest && clk_en |=> waitrequest)
    else $error("waitrequest low for more than one cycle");
  // a held enable must freeze the handshake and the detectors alike
  freeze_hold_a: assert property (!clk_en |=> $stable(waitrequest) && $stable(readdata)
    && $stable(up_code_detected) && $stable(down_code_detected)
    && $stable(spare_code_detected)) else $error("state moved while enable low");
  // readdata only moves when a read is taken, so a slow master still sees it
  rdata_hold_a: assert property (!(read && waitrequest) |=> $stable(readdata))
    else $error("readdata changed without a read");
  unmapped_zero_a: assert property (read && !waitrequest && address[1:0] != 2'b00
    |-> readdata == 32'h00000000) else $error("misaligned read not zero");
  spare_ctl_a: assert property (
    read && !waitrequest && address == {`SPARE_CODE_LENGTH_CTL_IDX, 2'b00}
    |-> readdata[31:3] == 29'h00000000) else $error("spare control upper bits not zero");
  det_reset_a: assert property (disable iff (1'b0)
    rst |=> !up_code_detected && !down_code_detected && !spare_code_detected)
    else $error("flag set after reset");
  up_restart_a: assert property (
    restart_p(`UP_CODE_PATTERN_HI_IDX, up_code_detected)) else $error("up not restarted");
  down_restart_a: assert property (
    restart_p(`DOWN_CODE_PATTERN_HI_IDX, down_code_detected)) else $error("down not restarted");
  spare_restart_a: assert property (
    restart_p(`SPARE_CODE_PATTERN_HI_IDX, spare_code_detected)) else $error("spare not restarted");
  det_rise_a: assert property (
    $rose(up_code_detected) || $rose(down_code_detected) || $rose(spare_code_detected)
    |-> $past(rx_bit_valid)) else $error("flag rose without a received bit");
  up_seen_c: cover property ($rose(up_code_detected));
  spare_seen_c: cover property ($rose(spare_code_detected));
  read_ack_c: cover property (read && !waitrequest);
endmodule

bind loop_code_detector loop_code_props loop_code_props_i (.core_clk, .rst, .clk_en,
  .address, .read, .write, .byteenable, .readdata, .waitrequest, .rx_bit_valid,
  .up_code_detected, .down_code_detected, .spare_code_detected);
`default_nettype wire

// ===== tb/t1_stream_model.sv
// Purpose: received line stream, repeating a code msb first.
// Assumes: go is a one-cycle pulse while busy is low.
// Notes: every fourth cycle carries no bit; between bits rx_bit keeps toggling.
`timescale 1ns/100ps
`default_nettype none

module t1_stream_model
(
  // clock and reset
  input wire logic core_clk,
  input wire logic rst,
  // burst request
  input wire logic go,
  input wire logic rewind,
  input wire logic [15:0] code,
  input wire logic [4:0] code_len,
  input wire logic [7:0] nbits,
  output logic busy,
  // line side
  output logic rx_bit_valid,
  output logic rx_bit
);
  logic [7:0] left_ff;
  logic [4:0] pos_ff;
  logic [1:0] phase_ff;
  // ****************************************
  // bit pump
  // ****************************************
  always @(posedge core_clk)
  begin
    rx_bit_valid <= 1'b0;
    rx_bit <= ~rx_bit;
    phase_ff <= phase_ff + 2'h1;
    if (rst)
    begin
      busy <= 1'b0;
      rx_bit <= 1'b0;
      phase_ff <= 2'h0;
      pos_ff <= 5'h00;
    end
    else if (go)
    begin
      busy <= 1'b1;
      left_ff <= nbits;
      // without rewind the code phase carries on across bursts
      if (rewind)
        pos_ff <= 5'h00;
    end
    else if (busy && phase_ff != 2'h3)
    begin
      rx_bit_valid <= 1'b1;
      rx_bit <= code[5'd15 - pos_ff];
      pos_ff <= (pos_ff + 5'h01 == code_len) ? 5'h00 : pos_ff + 5'h01;
      left_ff <= left_ff - 8'h01;
      busy <= (left_ff != 8'h01);
    end
  end
endmodule
`default_nettype wire

// ===== tb/tb_top.sv
// Purpose: self-checking bench of loop_code_detector.
// Assumes: one wait cycle per bus access, integration unit of 16 bits.
// Notes: reads queue their expectation; a monitor compares at the ack.
`timescale 1ns/100ps
`default_nettype none
`define CHK(nm, e, g) begin checked++; if ((g) !== (e)) begin mismatches++; \
  $display("BAD %s exp %h got %h", nm, e, g); end end

module tb_top;
  logic core_clk = 0, rst = 1, clk_en = 1, read = 0, write = 0, go = 0, rewind = 0;
  logic [9:0] address = 0;
  logic [31:0] writedata = 0;
  logic [3:0] byteenable = 4'h1;
  logic [31:0] readdata;
  logic waitrequest, rx_bit_valid, rx_bit, busy;
  logic up_code_detected, down_code_detected, spare_code_detected;
  logic [2:0] pins;
  assign pins = {spare_code_detected, down_code_detected, up_code_detected};
  logic [15:0] code = 0;
  logic [4:0] code_len = 5'h01;
  logic [7:0] nbits = 0;
  logic [73:0] note_q[$];
  logic [73:0] note;
  int mismatches = 0, checked = 0, cycles = 0, seed = 32;
  always #50 core_clk = ~core_clk;
  loop_code_detector loop_code_detector_i (.core_clk, .rst, .clk_en, .address, .read,
    .write, .writedata, .byteenable, .readdata, .waitrequest, .rx_bit_valid, .rx_bit,
    .up_code_detected, .down_code_detected, .spare_code_detected);
  t1_stream_model t1_stream_model_i (.core_clk, .rst, .go, .rewind, .code, .code_len,
    .nbits, .busy, .rx_bit_valid, .rx_bit);
  // ****************************************
  // tasks
  // ****************************************
  task automatic tally_and_finish();
    if (note_q.size() != 0)
      mismatches++;
    if (mismatches == 0 && checked > 0)
      $display("Run complete: PASS");
    else
      $display("Run complete: FAIL");
    $finish;
  endtask
  task automatic bus(input logic wr, input logic [7:0] idx, input logic [1:0] lo,
    input logic [7:0] d, input logic [3:0] be);
    read <= !wr;
    write <= wr;
    address <= {idx, lo};
    writedata <= ($random(seed) << 8) | d;
    byteenable <= be;
    @(posedge core_clk);
    while (waitrequest !== 1'b0) @(posedge core_clk);
    read <= 0;
    write <= 0;
    @(posedge core_clk);
  endtask
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    bus(1, idx, 2'b00, d, 4'h1);
  endtask
  task automatic rd(input logic [7:0] idx, input logic [1:0] lo, input logic [31:0] e, m);
    note_q.push_back({idx, lo, e, m});
    bus(0, idx, lo, 8'h00, 4'h1);
  endtask
  task automatic stream(input logic rw, input logic [7:0] n);
    rewind <= rw;
    nbits <= n;
    go <= 1;
    @(posedge core_clk);
    go <= 0;
    @(posedge core_clk);
    while (busy !== 1'b0) @(posedge core_clk);
  endtask
  // ****************************************
  // monitor and timeout
  // ****************************************
  always @(posedge core_clk)
    if (read && waitrequest === 1'b0)
    begin
      if (note_q.size() == 0)
        mismatches++;
      else
      begin
        note = note_q.pop_front();
        `CHK($sformatf("readdata@%h", note[73:64]), note[63:32], readdata & note[31:0])
        if (note[73:64] == {8'hf2, 2'b00})
          `CHK("detect pins", note[34:32], pins & note[2:0])
      end
    end
  always @(posedge core_clk)
  begin
    cycles++;
    if (cycles == 20000)
    begin
      mismatches++;
      tally_and_finish();
    end
  end
  // ****************************************
  // scenarios
  // ****************************************
  initial
  begin
    logic [7:0] v, hi, lo, pidx;
    int n;
    repeat (20) @(posedge core_clk);
    rst <= 0;
    @(posedge core_clk);
    for (int i = 'hb9; i <= 'hbf; i++) rd(8'(i), 2'b00, 0, 32'hffffffff);
    rd(8'hf0, 2'b00, 0, 32'hffffffff);
    rd(8'hf1, 2'b00, 32'h10, 32'hffffffff);
    rd(8'hb9, 2'b10, 0, 32'hffffffff);
    rd(8'h40, 2'b00, 0, 32'hffffffff);
    // misaligned and lane-off writes must leave the register alone
    bus(1, 8'hbe, 2'b01, 8'h5a, 4'h1);
    bus(1, 8'hbe, 2'b00, 8'ha5, 4'he);
    rd(8'hbe, 2'b00, 0, 32'hffffffff);
    for (int i = 'hb9; i <= 'hbf; i++)
    begin
      v = 8'($random(seed));
      if (i == 'hbd)
        v = v & 8'h07;
      wr(8'(i), v);
      rd(8'(i), 2'b00, (i == 'hbd) ? {29'h0, v[2:0]} : {24'h0, v}, 32'hffffffff);
    end
    wr(8'hf1, 8'h01);
    // a read issued with the enable low may only be answered once it returns
    clk_en <= 0;
    fork
      rd(8'hf1, 2'b00, 32'h01, 32'hffffffff);
      begin
        repeat (6) @(posedge core_clk);
        clk_en <= 1;
      end
    join
    for (int d = 0; d < 3; d++)
      for (int s = 0; s < 8; s++)
      begin
        hi = 8'($random(seed));
        lo = 8'($random(seed));
        n = (s == 7) ? 16 : s + 1;
        pidx = (d == 0) ? 8'hb9 : (d == 1) ? 8'hbb : 8'hbe;
        wr(pidx + 8'h01, lo);
        if (d == 2)
          wr(8'hbd, 8'(s));
        else
          wr(8'hf0, (d == 0) ? 8'(s << 3) : 8'(s));
        wr(pidx, hi);
        code <= {hi, lo};
        code_len <= 5'(n);
        stream(1, 8'(n + 8));
        rd(8'hf2, 2'b00, 0, 32'(1 << d));
        stream(0, 8'd24);
        rd(8'hf2, 2'b00, 32'(1 << d), 32'(1 << d));
        wr(pidx, hi);
        rd(8'hf2, 2'b00, 0, 32'(1 << d));
      end
    repeat (2) @(posedge core_clk);
    tally_and_finish();
  end
endmodule
`default_nettype wire
